/* File: sio_pkg.sv */
package sio_pkg;

  // ****************************************
  // bus widths and address fields
  // ****************************************
  localparam int SIO_ADDR_W = 16;
  localparam int SIO_DATA_W = 8;
  localparam int SIO_DEV_N = 8;
  localparam int SIO_TOP_MSB = 15;
  localparam int SIO_TOP_LSB = 14;
  localparam int SIO_SEL_MSB = 13;
  localparam int SIO_SEL_LSB = 11;
  localparam int SIO_POD_SEL_BIT = 0;

  // ****************************************
  // top address bit patterns
  // ****************************************
  localparam logic [1:0] SIO_IO_TOP = 2'h0;
  localparam logic [1:0] SIO_SCC_TOP = 2'h2;
  localparam logic [1:0] SIO_TIMER_TOP = 2'h1;

  // ****************************************
  // device select codes
  // ****************************************
  localparam logic [2:0] SIO_SEL_DISPLAY = 3'h1;
  localparam logic [2:0] SIO_SEL_INTERFACE = 3'h2;
  localparam logic [2:0] SIO_SEL_KEYBOARD = 3'h3;
  localparam logic [2:0] SIO_SEL_TICK = 3'h4;
  localparam logic [2:0] SIO_SEL_REMOTE = 3'h6;

  // ****************************************
  // timer port bit positions
  // ****************************************
  localparam int SIO_PA_LOCKOUT = 7;
  localparam int SIO_PA_DISC_IRQ = 5;
  localparam int SIO_PC_HDRIVE = 0;
  localparam int SIO_PC_SOFT_CLR = 1;
  localparam int SIO_PC_DISC_CLR = 2;
  localparam int SIO_PC_BEEPER = 3;

  // ****************************************
  // tick counter and reset values
  // ****************************************
  localparam int SIO_TICK_W = 6;
  localparam logic [SIO_TICK_W-1:0] SIO_TICK_LAST = 6'h3f;
  localparam logic [SIO_TICK_W-1:0] SIO_TICK_ZERO = 6'h00;
  localparam logic [SIO_TICK_W-1:0] SIO_TICK_ONE = 6'h01;
  localparam logic [SIO_DEV_N-1:0] SIO_DEV_IDLE = 8'hff;
  localparam logic [SIO_DATA_W-1:0] SIO_DATA_ZERO = 8'h00;
  localparam logic [1:0] SIO_POD_IDLE = 2'h0;
  localparam logic [1:0] SIO_POD_OE_IDLE = 2'h3;

  // active-low one-of-eight device enables for an I/O cycle
  function automatic logic [SIO_DEV_N-1:0] sio_io_select(
    input logic [SIO_ADDR_W-1:0] addr,
    input logic io_cycle
  );
    logic [SIO_DEV_N-1:0] en_n;
    en_n = SIO_DEV_IDLE;
    if (io_cycle && addr[SIO_TOP_MSB:SIO_TOP_LSB] == SIO_IO_TOP) begin
      en_n[addr[SIO_SEL_MSB:SIO_SEL_LSB]] = 1'b0;
    end
    return en_n;
  endfunction

endpackage

/* File: sio_io_decoder.sv */
`timescale 1ns/1ps
`default_nettype none

module sio_io_decoder (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [sio_pkg::SIO_ADDR_W-1:0] addr_i,
  input wire logic io_cycle_i,
  input wire logic strobe_i,
  output logic [sio_pkg::SIO_DEV_N-1:0] dev_enable_n_o
);
  import sio_pkg::*;

  logic [SIO_DEV_N-1:0] dev_en_n_ff;

  // ****************************************
  // registered one-hot select
  // ****************************************
  // only a strobed cycle drives an enable, so one bus cycle gives one enable
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      dev_en_n_ff <= SIO_DEV_IDLE;
    end else if (strobe_i) begin
      dev_en_n_ff <= sio_io_select(addr_i, io_cycle_i); // [RULE1] [RULE2] [RULE21]
    end else begin
      dev_en_n_ff <= SIO_DEV_IDLE; // [RULE1]
    end
  end

  assign dev_enable_n_o = dev_en_n_ff;

endmodule
`default_nettype wire

/* File: sio_tick_counter.sv */
`timescale 1ns/1ps
`default_nettype none

module sio_tick_counter (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic timer_zero_output_i,
  input wire logic clear_i,
  output logic [sio_pkg::SIO_TICK_W-1:0] count_o,
  output logic counter_third_bit_o
);
  import sio_pkg::*;

  logic tzero_prev_ff;
  logic tick_edge;
  logic [SIO_TICK_W-1:0] count_ff;
  logic third_ff;

  assign tick_edge = timer_zero_output_i && !tzero_prev_ff;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tzero_prev_ff <= 1'b0;
    end else begin
      tzero_prev_ff <= timer_zero_output_i;
    end
  end

  // ****************************************
  // count, clear on latch read
  // ****************************************
  // an edge in the clearing cycle is counted, not dropped
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      count_ff <= SIO_TICK_ZERO;
    end else if (clear_i) begin
      count_ff <= tick_edge ? SIO_TICK_ONE : SIO_TICK_ZERO; // [RULE10]
    end else if (tick_edge) begin
      count_ff <= count_ff + SIO_TICK_ONE; // [RULE7] [RULE22]
    end
  end

  // one-cycle pulse as the 64th count completes
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      third_ff <= 1'b0;
    end else begin
      third_ff <= tick_edge && !clear_i && count_ff == SIO_TICK_LAST; // [RULE8]
    end
  end

  assign count_o = count_ff;
  assign counter_third_bit_o = third_ff;

endmodule
`default_nettype wire

/* File: sio_system_io.sv */
// What this block does
// RULE1 - decode only on I/O cycle, top bits low
// RULE2 - three select bits pick one of eight
// RULE3 - outputs 1,2,3,4,6 go to named devices
// RULE4 - serial controller active-low chip enable
// RULE5 - active-high timer chip enable
// RULE6 - pod latch clocks and output enables
// RULE7 - tick counter counts timer zero output
// RULE8 - every 64 counts raise tick interrupt
// RULE9 - tick latch read returns current count
// RULE10 - tick latch read clears the counter
// RULE11 - port A drives lockout and disc irq
// RULE12 - port C bit 0 is horizontal drive
// RULE13 - port C bits clear softkey, disc irqs
// RULE14 - port C bit 3 gates beeper reset
// RULE15 - keyboard latch takes I/O write data
// RULE16 - CPU scans rows, reads columns back
// RULE17 - softkey event raises softkey interrupt
// RULE18 - CPU copies low address to high byte
// RULE19 - tick interrupt goes to restart-A input
// RULE20 - CPU flags I/O versus memory cycle
// RULE21 - enables active low, at most one
// RULE22 - counter steps per edge, else holds
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module sio_system_io (
  input wire logic clk_i,
  input wire logic reset_n_i,
  // ****************************************
  // cpu bus
  // ****************************************
  input wire logic [sio_pkg::SIO_ADDR_W-1:0] addr_i,
  input wire logic [sio_pkg::SIO_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic io_not_mem_i,
  output logic [sio_pkg::SIO_DATA_W-1:0] rdata_o,
  // ****************************************
  // device enables
  // ****************************************
  output logic display_controller_enable_n_o,
  output logic interface_latch_enable_n_o,
  output logic keyboard_latch_enable_n_o,
  output logic tick_latch_enable_n_o,
  output logic remote_latch_enable_n_o,
  output logic scc_chip_enable_n_o,
  output logic timer_chip_enable_o,
  // ****************************************
  // pod latches and keyboard
  // ****************************************
  output logic [1:0] pod_latch_clock_o,
  output logic [1:0] pod_latch_output_enable_n_o,
  output logic [sio_pkg::SIO_DATA_W-1:0] keyboard_row_o,
  // ****************************************
  // timer ports and interrupts
  // ****************************************
  input wire logic timer_zero_output_i,
  input wire logic [sio_pkg::SIO_DATA_W-1:0] timer_port_a_i,
  input wire logic [3:0] timer_port_c_i,
  input wire logic softkey_event_i,
  input wire logic disc_event_i,
  output logic counter_third_bit_o,
  output logic tick_interrupt_request_n_o,
  output logic softkey_interrupt_request_n_o,
  output logic disc_interrupt_request_n_o,
  output logic port_a_lockout_bit_o,
  output logic port_a_disc_irq_bit_o,
  output logic port_c_horizontal_drive_bit_o,
  output logic port_c_beeper_enable_o
);
  import sio_pkg::*;

  // ****************************************
  // bus qualification
  // ****************************************
  logic strobe;
  logic io_rd;
  logic io_wr;
  logic [SIO_DEV_N-1:0] sel_n;
  logic tick_read;
  logic kbd_write;
  logic pod_access;
  logic [1:0] top_bits;

  // the CPU mirrors the port number onto the high byte during I/O,
  // so the upper address lines decide the target, and bit 0 picks the pod latch [RULE18] [RULE20]
  assign strobe = wr_i || rd_i;
  assign io_rd = rd_i && io_not_mem_i;
  assign io_wr = wr_i && io_not_mem_i;
  assign sel_n = sio_io_select(addr_i, io_not_mem_i);
  assign tick_read = io_rd && !sel_n[SIO_SEL_TICK]; // [RULE9]
  assign kbd_write = io_wr && !sel_n[SIO_SEL_KEYBOARD]; // [RULE15]
  assign pod_access = !sel_n[SIO_SEL_INTERFACE] && strobe;
  assign top_bits = addr_i[SIO_TOP_MSB:SIO_TOP_LSB];

  // ****************************************
  // i/o select decoder
  // ****************************************
  logic [SIO_DEV_N-1:0] dev_en_n;

  sio_io_decoder u_decoder (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .addr_i(addr_i),
    .io_cycle_i(io_not_mem_i),
    .strobe_i(strobe),
    .dev_enable_n_o(dev_en_n)
  );

  // unused decoder outputs 0, 5 and 7 are simply not brought out
  assign display_controller_enable_n_o = dev_en_n[SIO_SEL_DISPLAY]; // [RULE3]
  assign interface_latch_enable_n_o = dev_en_n[SIO_SEL_INTERFACE]; // [RULE3]
  assign keyboard_latch_enable_n_o = dev_en_n[SIO_SEL_KEYBOARD]; // [RULE3]
  assign tick_latch_enable_n_o = dev_en_n[SIO_SEL_TICK]; // [RULE3]
  assign remote_latch_enable_n_o = dev_en_n[SIO_SEL_REMOTE]; // [RULE3]

  // ****************************************
  // serial controller and timer enables
  // ****************************************
  logic scc_en_n_ff;
  logic timer_en_ff;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      scc_en_n_ff <= 1'b1;
    end else begin
      scc_en_n_ff <= !(strobe && io_not_mem_i && top_bits == SIO_SCC_TOP); // [RULE4]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      timer_en_ff <= 1'b0;
    end else begin
      timer_en_ff <= strobe && io_not_mem_i && top_bits == SIO_TIMER_TOP; // [RULE5]
    end
  end

  assign scc_chip_enable_n_o = scc_en_n_ff;
  assign timer_chip_enable_o = timer_en_ff;

  // ****************************************
  // pod latch strobes
  // ****************************************
  // address bit 0 picks one of the two pod latches; a write clocks it,
  // a read opens its output for that one cycle
  logic [1:0] pod_clk_ff;
  logic [1:0] pod_oe_n_ff;
  logic [1:0] pod_pick;

  assign pod_pick = addr_i[SIO_POD_SEL_BIT] ? 2'h2 : 2'h1;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pod_clk_ff <= SIO_POD_IDLE;
    end else if (pod_access && wr_i) begin
      pod_clk_ff <= pod_pick; // [RULE6]
    end else begin
      pod_clk_ff <= SIO_POD_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pod_oe_n_ff <= SIO_POD_OE_IDLE;
    end else if (pod_access && rd_i) begin
      pod_oe_n_ff <= ~pod_pick; // [RULE6]
    end else begin
      pod_oe_n_ff <= SIO_POD_OE_IDLE;
    end
  end

  assign pod_latch_clock_o = pod_clk_ff;
  assign pod_latch_output_enable_n_o = pod_oe_n_ff;

  // ****************************************
  // keyboard scan latch
  // ****************************************
  // software drives one row here, then reads columns through port A,
  // which lives in the timer, not in this block [RULE16]
  logic [SIO_DATA_W-1:0] kbd_row_ff;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      kbd_row_ff <= SIO_DATA_ZERO;
    end else if (kbd_write) begin
      kbd_row_ff <= wdata_i; // [RULE15]
    end
  end

  assign keyboard_row_o = kbd_row_ff;

  // ****************************************
  // tick counter
  // ****************************************
  logic [SIO_TICK_W-1:0] tick_count;
  logic tick_wrap;

  sio_tick_counter u_tick (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .timer_zero_output_i(timer_zero_output_i),
    .clear_i(tick_read),
    .count_o(tick_count),
    .counter_third_bit_o(tick_wrap)
  );

  assign counter_third_bit_o = tick_wrap;

  // ****************************************
  // read data
  // ****************************************
  // only the tick latch answers; any other read returns zero
  logic [SIO_DATA_W-1:0] rdata_ff;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_ff <= SIO_DATA_ZERO;
    end else if (tick_read) begin
      rdata_ff <= {{(SIO_DATA_W-SIO_TICK_W){1'b0}}, tick_count}; // [RULE9]
    end else begin
      rdata_ff <= SIO_DATA_ZERO;
    end
  end

  assign rdata_o = rdata_ff;

  // ****************************************
  // interrupt latches
  // ****************************************
  // every latch lets a new event win over a clear in the same cycle,
  // so a wrap that lands on the servicing read is never lost
  logic tick_irq_n_ff;
  logic soft_irq_n_ff;
  logic disc_irq_n_ff;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tick_irq_n_ff <= 1'b1;
    end else if (tick_wrap) begin
      tick_irq_n_ff <= 1'b0; // [RULE8] [RULE19]
    end else if (tick_read) begin
      tick_irq_n_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      soft_irq_n_ff <= 1'b1;
    end else if (softkey_event_i) begin
      soft_irq_n_ff <= 1'b0; // [RULE17]
    end else if (timer_port_c_i[SIO_PC_SOFT_CLR]) begin
      soft_irq_n_ff <= 1'b1; // [RULE13]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      disc_irq_n_ff <= 1'b1;
    end else if (disc_event_i) begin
      disc_irq_n_ff <= 1'b0;
    end else if (timer_port_c_i[SIO_PC_DISC_CLR]) begin
      disc_irq_n_ff <= 1'b1; // [RULE13]
    end
  end

  assign tick_interrupt_request_n_o = tick_irq_n_ff;
  assign softkey_interrupt_request_n_o = soft_irq_n_ff;
  assign disc_interrupt_request_n_o = disc_irq_n_ff;

  // ****************************************
  // timer port outputs
  // ****************************************
  // one flop of delay keeps every output registered; the loads here
  // (deflection, beeper, arbiter hold) are far slower than one cycle
  logic lockout_ff;
  logic disc_out_ff;
  logic hdrive_ff;
  logic beeper_ff;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      lockout_ff <= 1'b0;
      disc_out_ff <= 1'b0;
    end else begin
      lockout_ff <= timer_port_a_i[SIO_PA_LOCKOUT]; // [RULE11]
      disc_out_ff <= timer_port_a_i[SIO_PA_DISC_IRQ]; // [RULE11]
    end
  end

  // drive and beeper stay off through reset until software enables them
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      hdrive_ff <= 1'b0;
      beeper_ff <= 1'b0;
    end else begin
      hdrive_ff <= timer_port_c_i[SIO_PC_HDRIVE]; // [RULE12]
      beeper_ff <= timer_port_c_i[SIO_PC_BEEPER]; // [RULE14]
    end
  end

  assign port_a_lockout_bit_o = lockout_ff;
  assign port_a_disc_irq_bit_o = disc_out_ff;
  assign port_c_horizontal_drive_bit_o = hdrive_ff;
  assign port_c_beeper_enable_o = beeper_ff;

endmodule
`default_nettype wire

/* File: sio_system_io_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module sio_system_io_monitor (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [sio_pkg::SIO_ADDR_W-1:0] addr_i,
  input wire logic [sio_pkg::SIO_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic io_not_mem_i,
  input wire logic [sio_pkg::SIO_DATA_W-1:0] rdata_o,
  input wire logic display_controller_enable_n_o,
  input wire logic interface_latch_enable_n_o,
  input wire logic keyboard_latch_enable_n_o,
  input wire logic tick_latch_enable_n_o,
  input wire logic remote_latch_enable_n_o,
  input wire logic scc_chip_enable_n_o,
  input wire logic timer_chip_enable_o,
  input wire logic [1:0] pod_latch_clock_o,
  input wire logic [1:0] pod_latch_output_enable_n_o,
  input wire logic [sio_pkg::SIO_DATA_W-1:0] keyboard_row_o,
  input wire logic [sio_pkg::SIO_DATA_W-1:0] timer_port_a_i,
  input wire logic [3:0] timer_port_c_i,
  input wire logic softkey_event_i,
  input wire logic counter_third_bit_o,
  input wire logic tick_interrupt_request_n_o,
  input wire logic softkey_interrupt_request_n_o,
  input wire logic port_a_lockout_bit_o,
  input wire logic port_a_disc_irq_bit_o,
  input wire logic port_c_horizontal_drive_bit_o,
  input wire logic port_c_beeper_enable_o
);
  import sio_pkg::*;
  logic io_acc;
  logic io_top;
  logic tick_rd;
  logic [4:0] en_n;
  assign io_acc = (wr_i | rd_i) & io_not_mem_i;
  assign io_top = io_acc && addr_i[15:14] == SIO_IO_TOP;
  assign tick_rd = rd_i && io_top && addr_i[13:11] == SIO_SEL_TICK;
  assign en_n = {display_controller_enable_n_o, interface_latch_enable_n_o,
    keyboard_latch_enable_n_o, tick_latch_enable_n_o, remote_latch_enable_n_o};
  function automatic logic [4:0] sel_n(input logic [2:0] s);
    sel_n = ~{s == SIO_SEL_DISPLAY, s == SIO_SEL_INTERFACE,
      s == SIO_SEL_KEYBOARD, s == SIO_SEL_TICK, s == SIO_SEL_REMOTE};
  endfunction
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ****************************************
  // decoders
  // ****************************************
  a_mem_no_enable: assert property (
    (wr_i | rd_i) && !io_not_mem_i |=> &en_n && scc_chip_enable_n_o
    && !timer_chip_enable_o) else $error("enable on memory cycle");
  a_dev_select: assert property (
    io_top |=> en_n == sel_n($past(addr_i[13:11])))
    else $error("wrong device enable");
  a_one_hot: assert property ($countones(~en_n) <= 1)
    else $error("several device enables");
  a_scc_enable: assert property (reset_n_i |=>
    scc_chip_enable_n_o == !$past(io_acc && addr_i[15:14] == SIO_SCC_TOP))
    else $error("serial enable wrong");
  a_timer_enable: assert property (reset_n_i |=>
    timer_chip_enable_o == $past(io_acc && addr_i[15:14] == SIO_TIMER_TOP))
    else $error("timer enable wrong");
  a_pod_clock: assert property (
    wr_i && io_top && addr_i[13:11] == SIO_SEL_INTERFACE
    |=> pod_latch_clock_o == ($past(addr_i[0]) ? 2'b10 : 2'b01))
    else $error("pod clock wrong");
  a_pod_output_enable: assert property (
    rd_i && io_top && addr_i[13:11] == SIO_SEL_INTERFACE
    |=> pod_latch_output_enable_n_o == ($past(addr_i[0]) ? 2'b01 : 2'b10))
    else $error("pod output enable wrong");
  a_kbd_capture: assert property (
    wr_i && io_top && addr_i[13:11] == SIO_SEL_KEYBOARD
    |=> keyboard_row_o == $past(wdata_i)) else $error("row not latched");
  // ****************************************
  // tick, interrupts, ports
  // ****************************************
  a_rdata_zero: assert property (
    rd_i && !tick_rd |=> rdata_o == SIO_DATA_ZERO)
    else $error("data on non-tick read");
  a_read_clears: assert property (
    tick_rd && !counter_third_bit_o |=> tick_interrupt_request_n_o)
    else $error("tick irq kept after read");
  a_wrap_irq: assert property (
    counter_third_bit_o |=> !tick_interrupt_request_n_o)
    else $error("tick irq missing");
  a_softkey_set: assert property (
    softkey_event_i |=> !softkey_interrupt_request_n_o)
    else $error("softkey irq missing");
  a_softkey_clr: assert property (
    timer_port_c_i[1] && !softkey_event_i |=> softkey_interrupt_request_n_o)
    else $error("softkey irq not cleared");
  a_port_copy: assert property (reset_n_i |=>
    {port_a_lockout_bit_o, port_a_disc_irq_bit_o,
    port_c_horizontal_drive_bit_o, port_c_beeper_enable_o} ==
    $past({timer_port_a_i[7], timer_port_a_i[5], timer_port_c_i[0],
    timer_port_c_i[3]})) else $error("port copy wrong");
  c_tick_read: cover property (tick_rd);
  c_wrap: cover property (counter_third_bit_o);
  c_pod_write: cover property (wr_i && io_top && addr_i[13:11] == 3'h2);
endmodule
`default_nettype wire

/* File: sio_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sio_cpu_model (
  input wire logic clk_i,
  output logic [sio_pkg::SIO_ADDR_W-1:0] addr_o,
  output logic [sio_pkg::SIO_DATA_W-1:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  output logic io_o
);
  import sio_pkg::*;
  initial begin
    addr_o = 16'h0000;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    io_o = 1'b0;
  end
  // one strobed cycle; calls may follow each other with no gap
  task automatic cyc(input logic w, input logic io, input logic [7:0] p,
    input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= io ? {p, p} : {p, ~p};
    io_o <= io;
    wdata_o <= w ? d : ~d;
    wr_o <= w;
    rd_o <= !w;
  endtask
  // released lines flip so a stale value is never mistaken for data
  task automatic idle();
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~addr_o;
    wdata_o <= ~wdata_o;
  endtask
endmodule
`default_nettype wire

/* File: sio_system_io_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module sio_system_io_bench;
  import sio_pkg::*;
  logic clk_i, reset_n_i, wr_i, rd_i, io_not_mem_i, timer_zero_output_i;
  logic softkey_event_i, disc_event_i;
  logic rd_seen = 1'b0;
  logic [SIO_ADDR_W-1:0] addr_i;
  logic [SIO_DATA_W-1:0] wdata_i, rdata_o, keyboard_row_o, timer_port_a_i;
  logic [SIO_DATA_W-1:0] kb;
  logic [3:0] timer_port_c_i;
  logic [1:0] pod_latch_clock_o, pod_latch_output_enable_n_o;
  logic display_controller_enable_n_o, interface_latch_enable_n_o;
  logic keyboard_latch_enable_n_o, tick_latch_enable_n_o;
  logic remote_latch_enable_n_o, scc_chip_enable_n_o, timer_chip_enable_o;
  logic counter_third_bit_o, tick_interrupt_request_n_o;
  logic softkey_interrupt_request_n_o, disc_interrupt_request_n_o;
  logic port_a_lockout_bit_o, port_a_disc_irq_bit_o;
  logic port_c_horizontal_drive_bit_o, port_c_beeper_enable_o;
  logic [5:0] n;
  int err_total, n_checks, seed, i;
  logic [7:0] exp_q[$];
  sio_system_io sio_system_io_i (.*);
  sio_cpu_model sio_cpu_model_i (.clk_i(clk_i), .addr_o(addr_i),
    .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i), .io_o(io_not_mem_i));
  always #2.5 clk_i = ~clk_i;
  task automatic check(input string nm, input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rd(input logic io, input logic [7:0] p, input logic [7:0] e);
    exp_q.push_back(e);
    sio_cpu_model_i.cyc(1'b0, io, p, 8'h00);
  endtask
  // timer edges two cycles apart, ports stirred meanwhile
  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge clk_i);
      timer_zero_output_i <= 1'b1;
      timer_port_a_i <= 8'($random(seed));
      timer_port_c_i <= 4'($random(seed));
      @(posedge clk_i);
      timer_zero_output_i <= 1'b0;
    end
    timer_port_c_i <= 4'h0;
  endtask
  // ****************************************
  // read data watcher
  // ****************************************
  always @(posedge clk_i) rd_seen <= rd_i;
  always @(negedge clk_i) begin
    if (rd_seen && exp_q.size() > 0) check("rdata", rdata_o, exp_q.pop_front());
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clk_i = 1'b0;
    seed = 32'hd634;
    reset_n_i <= 1'b0;
    timer_zero_output_i <= 1'b0;
    softkey_event_i <= 1'b0;
    disc_event_i <= 1'b0;
    timer_port_a_i <= 8'h00;
    timer_port_c_i <= 4'h0;
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      rd(1'b1, 8'(s * 8), 8'h00);
      rd(1'b0, 8'(s * 8), 8'h00);
    end
    rd(1'b1, 8'h80, 8'h00);
    rd(1'b1, 8'h40, 8'h00);
    sio_cpu_model_i.cyc(1'b1, 1'b1, 8'h10, 8'h00);
    sio_cpu_model_i.cyc(1'b1, 1'b1, 8'h11, 8'h00);
    kb = 8'($random(seed));
    sio_cpu_model_i.cyc(1'b1, 1'b1, 8'h18, kb);
    sio_cpu_model_i.cyc(1'b1, 1'b1, 8'h30, ~kb);
    sio_cpu_model_i.idle();
    @(negedge clk_i);
    check("keyboard row", keyboard_row_o, kb);
    n = 6'($random(seed));
    pulses(int'(n));
    rd(1'b1, 8'h20, {2'b00, n});
    rd(1'b1, 8'h20, 8'h00);
    sio_cpu_model_i.idle();
    pulses(64);
    @(negedge clk_i);
    check("wrap pulse", counter_third_bit_o, 8'h01);
    i = 0;
    while (tick_interrupt_request_n_o !== 1'b0 && i < 8) begin
      @(negedge clk_i);
      i++;
    end
    if (tick_interrupt_request_n_o !== 1'b0) begin
      err_total++;
      tally_and_finish();
    end
    check("tick irq set", tick_interrupt_request_n_o, 8'h00);
    rd(1'b1, 8'h20, 8'h00);
    sio_cpu_model_i.idle();
    @(negedge clk_i);
    check("tick irq clr", tick_interrupt_request_n_o, 8'h01);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      softkey_event_i <= (k == 0);
      disc_event_i <= (k == 1);
      @(posedge clk_i);
      softkey_event_i <= 1'b0;
      disc_event_i <= 1'b0;
      @(negedge clk_i);
      check("irq set", k ? disc_interrupt_request_n_o :
        softkey_interrupt_request_n_o, 8'h00);
      @(posedge clk_i);
      timer_port_c_i <= k ? 4'h4 : 4'h2;
      @(posedge clk_i);
      timer_port_c_i <= 4'h0;
      @(negedge clk_i);
      check("irq clr", k ? disc_interrupt_request_n_o :
        softkey_interrupt_request_n_o, 8'h01);
    end
    repeat (4) @(posedge clk_i);
    tally_and_finish();
  end
endmodule
bind sio_system_io sio_system_io_monitor sio_system_io_monitor_i (.*);
`default_nettype wire
